// ===== tb/psr_far_port.sv
`timescale 1ns/10ps
module psr_far_port
   import psr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire psr_line_type tx_line,
   input wire logic cable_bias_output,
   input wire logic cable_bias_oe_b,
   input wire logic resume_event,
   input wire logic answer_en,
   input wire logic [3:0] answer_dly,
   input wire logic drop_req,
   input wire logic notify_req,
   output logic bias_in_low,
   output logic rx_ident_done
);
   logic [3:0] wait_cnt;
   logic notified;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bias_in_low <= 1'b0;
         rx_ident_done <= 1'b0;
         wait_cnt <= 4'h0;
         notified <= 1'b0;
      end else begin
         rx_ident_done <= notify_req;
         wait_cnt <= (tx_line == LINE_SUSPEND_NOTIFY && answer_en) ? wait_cnt + 4'h1 : 4'h0;
         if (resume_event) begin
            bias_in_low <= 1'b0;
            notified <= 1'b0;
         end else if (notify_req) begin
            notified <= 1'b1;
         end else if (drop_req || (answer_en && wait_cnt == answer_dly && tx_line == LINE_SUSPEND_NOTIFY)) begin
            bias_in_low <= 1'b1;
         end else if (notified && !cable_bias_oe_b && !cable_bias_output) begin
            bias_in_low <= 1'b1;
         end
      end
   end
endmodule : psr_far_port

// ===== tb/psr_port_suspend_asserts.sv
`timescale 1ns/10ps
module psr_port_suspend_asserts
   import psr_pkg::*;
#(
   parameter logic [4:0] PORT_NUM = 5'h00,
   parameter int BIAS_CYC = BIAS_HOLD_CYC,
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [5:0] node_id,
   input wire psr_pkt_type req,
   input wire logic arb_grant,
   input wire psr_pkt_type rsp,
   input wire psr_pkt_type bcast,
   input wire logic arb_req,
   input wire psr_line_type tx_line,
   input wire logic short_reset_others,
   input wire logic notify_others,
   input wire logic resume_event,
   input wire logic long_reset,
   input wire logic cable_bias_output,
   input wire logic cable_bias_oe_b,
   input wire logic [7:0] control
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   int low_cnt;
   int res_cnt;
   logic wr_hit;
   assign wr_hit = req.valid && req.port == PORT_NUM && req.kind == TYPE_WRITE;
   // Cycles of low bias drive, cycles since resume
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt <= 0;
         res_cnt <= 0;
      end else begin
         low_cnt <= (!cable_bias_oe_b && !cable_bias_output) ? low_cnt + 1 : 0;
         res_cnt <= resume_event ? 1 : ((res_cnt != 0) ? res_cnt + 1 : 0);
      end
   end
   chk_rsp_form: assert property (
      wr_hit |=> rsp.valid && rsp.kind == TYPE_RESPONSE && rsp.phy_id == node_id) else $error("bad response");
   chk_set_bits: assert property (
      wr_hit && req.sel == REG_CONTROL_SET |=>
      (control & $past(req.value) & CTL_WRITABLE) == ($past(req.value) & CTL_WRITABLE)) else $error("set failed");
   chk_clear_bits: assert property (
      wr_hit && req.sel == REG_CONTROL_CLEAR |=>
      (control & $past(req.value) & CTL_WRITABLE) == 8'h00) else $error("clear failed");
   chk_status_ro: assert property (
      wr_hit && req.sel <= REG_STATUS_SECOND |=> control == $past(control)) else $error("status written");
   chk_notify_seq: assert property (
      tx_line == LINE_DATA_END |=> tx_line == LINE_SUSPEND_NOTIFY && short_reset_others) else $error("no notify");
   chk_quiet_susp: assert property (
      control[CTL_SUSPEND] && $past(control[CTL_SUSPEND]) |-> !short_reset_others && !notify_others)
      else $error("suspended port active");
   chk_bias_hold: assert property (
      $rose(cable_bias_oe_b) && low_cnt != 0 |-> low_cnt >= BIAS_CYC && low_cnt <= BIAS_CYC + 1)
      else $error("bias hold length");
   chk_resume_drive: assert property (
      resume_event |-> ##[0:1] (!cable_bias_oe_b && cable_bias_output && !control[CTL_SUSPEND]))
      else $error("resume without bias");
   chk_long_delay: assert property (
      long_reset |-> res_cnt >= 5 * DEBOUNCE_CYCLES - 1 && res_cnt <= 5 * DEBOUNCE_CYCLES + 1)
      else $error("long reset timing");
   chk_bcast_grant: assert property (
      arb_req && arb_grant |=> bcast.valid && !arb_req && bcast.kind == TYPE_WRITE && bcast.port == PORT_NUM
      && bcast.value[CTL_SUSPEND] && bcast.phy_id == node_id) else $error("broadcast missing");
   cov_resume: cover property (resume_event);
   cov_notify: cover property (tx_line == LINE_SUSPEND_NOTIFY);
   cov_target: cover property (notify_others);
endmodule : psr_port_suspend_asserts

bind psr_port_suspend psr_port_suspend_asserts #(.PORT_NUM(PORT_NUM), .BIAS_CYC(BIAS_CYC),
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_u (.*);

// ===== tb/psr_port_suspend_tb.sv
`timescale 1ns/10ps
module psr_port_suspend_tb
   import psr_pkg::*;
;
   localparam logic [4:0] PN = 5'h03;
   localparam int DEB = 4;
   logic core_clk, rst_b, arb_grant, bias_in_low, conn_sense, rx_ident_done, self_id_expected;
   logic bus_reset_in, node_wr_en, arb_req, short_reset_others, notify_others, resume_event;
   logic long_reset, reset_taken, status_pkt, cable_bias_output, cable_bias_oe_b;
   logic answer_en, drop_req, notify_req;
   logic [3:0] answer_dly;
   logic [5:0] node_id;
   logic [2:0] node_wr_addr;
   logic [7:0] node_wr_data, control;
   logic [10:0] ev;
   psr_pkt_type req, rsp, bcast;
   psr_line_type tx_line;
   int n_mismatch, n_compared, cyc;
   psr_port_suspend #(.PORT_NUM(PN), .NOTIFY_CYC(8), .BIAS_CYC(8), .DEBOUNCE_CYCLES(DEB)) dut_u (.*);
   psr_far_port far_u (.*);
   assign ev = {reset_taken, status_pkt, bcast.valid, arb_req, cable_bias_oe_b, short_reset_others, notify_others,
      tx_line == LINE_SUSPEND_NOTIFY, long_reset, resume_event, control[CTL_SUSPEND]};
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   task automatic wrap_up;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Bounded wait for one event bit
   task automatic wt(input int b, input int lim, output int n);
      n = 0;
      #1;
      while (ev[b] !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk($sformatf("event_%0d", b), 8'h01, {7'h0, ev[b]});
   endtask : wt
   task automatic send(input logic [5:0] k, input logic [4:0] p, input logic [2:0] s, input logic [7:0] v,
      input logic lk);
      @(posedge core_clk);
      req <= '{1'b1, lk, k, 6'h05, p, s, v};
      @(posedge core_clk);
      req.valid <= 1'b0;
      #1;
   endtask : send
   task automatic t_resume(input logic [7:0] clr);
      int n;
      if (clr == 8'h00) begin
         send(TYPE_RESUME, RESUME_PORT, REG_CONTROL_CLEAR, RESUME_VALUE, 1'b0);
      end else if (clr != 8'hff) begin
         send(TYPE_WRITE, PN, REG_CONTROL_CLEAR, clr, 1'b0);
      end
      wt(1, 6, n);
      wt(2, 5 * DEB + 4, n);
      chk("long_reset_late", 8'h01, {7'h0, n >= 5 * DEB - 1});
      chk("suspend_bit", 8'h00, {7'h0, control[CTL_SUSPEND]});
   endtask : t_resume
   task automatic t_regs;
      int n;
      send(TYPE_WRITE, PN, REG_STATUS_FIRST, 8'h1d, 1'b0);
      send(TYPE_WRITE, PN, REG_STATUS_SECOND, 8'h1d, 1'b0);
      chk("ctl_status_wr", 8'h00, control);
      send(TYPE_WRITE, PN, REG_CONTROL_SET, 8'h1d, 1'b0);
      chk("ctl_set", 8'h1d, control);
      wt(6, 2, n);
      send(TYPE_READ, PN, REG_CONTROL_CLEAR, 8'h00, 1'b0);
      chk("read_clear_sel", 8'h1d, rsp.value);
      send(TYPE_WRITE, PN, REG_CONTROL_CLEAR, 8'h10, 1'b0);
      chk("ctl_clear", 8'h0d, control);
      wt(9, 3, n);
      send(TYPE_READ, PN, REG_CONTROL_SET, 8'h00, 1'b0);
      chk("read_set_sel", 8'h0d, rsp.value);
      send(TYPE_WRITE, PN, REG_CONTROL_CLEAR, 8'h0d, 1'b0);
      @(posedge core_clk);
      node_wr_en <= 1'b1;
      @(posedge core_clk);
      node_wr_en <= 1'b0;
      send(TYPE_WRITE, PORT_SEL_NODE, 3'h3, 8'h00, 1'b0);
      @(posedge core_clk);
      #1;
      chk("node_reg", 8'h5a, rsp.value);
   endtask : t_regs
   task automatic t_init;
      int n;
      send(TYPE_WRITE, PN, REG_CONTROL_SET, 8'h02, 1'b0);
      chk("rsp_old_ctl", 8'h00, rsp.value);
      wt(3, 4, n);
      chk("short_reset", 8'h01, {7'h0, short_reset_others});
      wt(0, 12, n);
      wt(6, 12, n);
      t_resume(8'h00);
   endtask : t_init
   task automatic t_timeout;
      int n;
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         answer_en <= 1'b0;
         send(TYPE_WRITE, PN, REG_CONTROL_SET, 8'h02, 1'b0);
         wt(3, 4, n);
         @(posedge core_clk);
         conn_sense <= (i == 0);
         wt(0, 20, n);
         @(posedge core_clk);
         #1;
         chk("ctl_timeout", (i == 0) ? 8'h12 : 8'h02, control);
         @(posedge core_clk);
         conn_sense <= 1'b1;
         t_resume((i == 0) ? 8'h12 : 8'hff);
      end
      @(posedge core_clk);
      answer_en <= 1'b1;
   endtask : t_timeout
   task automatic t_target;
      int n;
      @(posedge core_clk);
      notify_req <= 1'b1;
      @(posedge core_clk);
      notify_req <= 1'b0;
      wt(4, 4, n);
      wt(0, 12, n);
      wt(6, 12, n);
      t_resume(8'h00);
   endtask : t_target
   task automatic t_link;
      int n;
      @(posedge core_clk);
      answer_dly <= 4'h6;
      send(TYPE_WRITE, PN, REG_CONTROL_SET, 8'h02, 1'b1);
      wt(7, 4, n);
      @(posedge core_clk);
      arb_grant <= 1'b1;
      wt(8, 4, n);
      chk("bcast_value", 8'h02, bcast.value);
      chk("bcast_port", {3'h0, PN}, {3'h0, bcast.port});
      @(posedge core_clk);
      arb_grant <= 1'b0;
      wt(3, 4, n);
      wt(0, 16, n);
      wt(6, 12, n);
      t_resume(8'h00);
   endtask : t_link
   task automatic t_loss;
      int n;
      @(posedge core_clk);
      drop_req <= 1'b1;
      @(posedge core_clk);
      drop_req <= 1'b0;
      wt(5, 4, n);
      wt(0, 2, n);
      wt(6, 12, n);
      t_resume(8'h02);
   endtask : t_loss
   task automatic t_busrst;
      int n;
      @(posedge core_clk);
      bus_reset_in <= 1'b1;
      wt(10, 3, n);
      @(posedge core_clk);
      drop_req <= 1'b1;
      @(posedge core_clk);
      drop_req <= 1'b0;
      wt(0, 4, n);
      n = 0;
      repeat (12) begin
         @(posedge core_clk);
         #1;
         n = n + int'(reset_taken);
      end
      chk("reset_taken_susp", 8'h00, 8'(n));
      send(TYPE_RESUME, RESUME_PORT, REG_CONTROL_CLEAR, RESUME_VALUE, 1'b0);
      wt(10, 3, n);
      @(posedge core_clk);
      bus_reset_in <= 1'b0;
   endtask : t_busrst
   initial begin
      rst_b = 1'b0;
      conn_sense = 1'b1;
      {arb_grant, self_id_expected, bus_reset_in, node_wr_en, drop_req, notify_req} = 6'h00;
      answer_en = 1'b1;
      answer_dly = 4'h1;
      node_id = 6'h05;
      node_wr_addr = 3'h3;
      node_wr_data = 8'h5a;
      req = '0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk("ctl_reset", CTL_RESET, control);
      t_resume(8'h00);
      t_regs;
      t_init;
      t_timeout;
      t_target;
      t_link;
      t_loss;
      t_busrst;
      wrap_up;
   end
endmodule : psr_port_suspend_tb

// ===== verilog/psr_node_regs.sv
`timescale 1ns/10ps
module psr_node_regs
   import psr_pkg::*;
#(
   parameter int DEPTH = NODE_REGS,
   parameter int AW = NODE_AW,
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic rst_sync_b,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0] rd_data;
   } psr_mem_type;

   psr_mem_type s;
   psr_mem_type next_s;

   always_comb begin
      next_s = s;
      if (wr_en) begin
         next_s.mem[wr_addr] = wr_data;
      end
      next_s.rd_data = s.mem[rd_addr];
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data = s.rd_data;

endmodule : psr_node_regs

// ===== verilog/psr_pkg.sv
package psr_pkg;

   // Clock and hold intervals
   localparam int CLK_PERIOD_NS = 100;
   localparam int NOTIFY_HOLD_NS = 166670;
   localparam int BIAS_HOLD_NS = 166670;
   localparam int NOTIFY_HOLD_CYC = (NOTIFY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIAS_HOLD_CYC = (BIAS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEBOUNCE_NS = 85000000;
   localparam int DEBOUNCE_CYC = DEBOUNCE_NS / CLK_PERIOD_NS;
   localparam int RESUME_DEBOUNCES = 5;
   localparam int TIMER_W = 24;

   // Packet type codes
   localparam logic [5:0] TYPE_READ = 6'h00;
   localparam logic [5:0] TYPE_WRITE = 6'h01;
   localparam logic [5:0] TYPE_RESUME = 6'h02;
   localparam logic [5:0] TYPE_RESPONSE = 6'h3f;

   // Port and register selectors
   localparam logic [4:0] PORT_SEL_MAX = 5'h1a;
   localparam logic [4:0] PORT_SEL_NODE = 5'h1f;
   localparam logic [4:0] RESUME_PORT = 5'h00;
   localparam logic [7:0] RESUME_VALUE = 8'h02;
   localparam logic [2:0] REG_STATUS_FIRST = 3'h0;
   localparam logic [2:0] REG_STATUS_SECOND = 3'h1;
   localparam logic [2:0] REG_CONTROL_SET = 3'h2;
   localparam logic [2:0] REG_CONTROL_CLEAR = 3'h3;

   // Control register fields
   localparam int CTL_CHG_INT_EN = 0;
   localparam int CTL_SUSPEND = 1;
   localparam int CTL_DISABLE = 2;
   localparam int CTL_ENAB_TOKEN = 3;
   localparam int CTL_FAULT = 4;
   localparam logic [7:0] CTL_RESET = 8'h02;
   localparam logic [7:0] CTL_WRITABLE = 8'h1d;

   // Status fields
   localparam int ST_CON = 0;
   localparam int ST_BIAS = 1;
   localparam int ST_SUSPEND = 2;
   localparam int ST_DISABLE = 3;
   localparam int ST_FAULT = 4;
   localparam int ST2_INITIATOR = 0;
   localparam int ST2_TARGET = 1;
   localparam int ST2_RESUMING = 2;

   // Node register memory
   localparam int NODE_REGS = 8;
   localparam int NODE_AW = 3;

   typedef enum logic [3:0] {
      ST_ACTIVE, ST_INIT_ARB, ST_INIT_END, ST_INIT_NOTIFY, ST_SAMPLE,
      ST_BIAS_HOLD, ST_TGT_HOLD, ST_SUSPENDED, ST_RESUME_WAIT
   } psr_state_type;

   typedef enum logic [1:0] {
      LINE_IDLE, LINE_DATA_END, LINE_SUSPEND_NOTIFY
   } psr_line_type;

   typedef struct packed {
      logic valid;
      logic from_link;
      logic [5:0] kind;
      logic [5:0] phy_id;
      logic [4:0] port;
      logic [2:0] sel;
      logic [7:0] value;
   } psr_pkt_type;

endpackage : psr_pkg

// ===== verilog/psr_port_suspend.sv
`timescale 1ns/10ps
// What this block does
// - resume packet clears suspend, fires resume event
// - long reset after five debounce intervals
// - status registers are read-only
// - set and clear selects read control register
// - set writes set, clear writes clear bits
// - port 31 reads node registers only
// - suspend write selects port as initiator
// - bias loss sets suspend, low bias, tristate
// - bias loss short-resets other active ports
// - suspended port ignores resets and notifications
// - initiator answers write with control value
// - data end, short reset others, notify target
// - notify hold, then suspend and bias hold
// - notify timeout samples sense: fault or disconnected
// - faulted port disconnecting clears fault silently
// - fault clears when bias drops, silently
// - link suspend arbitrates and broadcasts write first
// - unexpected ident-done means suspend notification
// - target repeats notify, drives low bias
// - target sets suspend on low incoming bias
// - target timeout: fault or disconnected suspend
// - status packet on status bit change
// - disabled port ignores resets, notify, resume
module psr_port_suspend
   import psr_pkg::*;
#(
   parameter logic [4:0] PORT_NUM = 5'h00,
   parameter int NOTIFY_CYC = NOTIFY_HOLD_CYC,
   parameter int BIAS_CYC = BIAS_HOLD_CYC,
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [5:0] node_id,
   input wire psr_pkt_type req,
   input wire logic arb_grant,
   input wire logic bias_in_low,
   input wire logic conn_sense,
   input wire logic rx_ident_done,
   input wire logic self_id_expected,
   input wire logic bus_reset_in,
   input wire logic node_wr_en,
   input wire logic [NODE_AW-1:0] node_wr_addr,
   input wire logic [7:0] node_wr_data,
   output psr_pkt_type rsp,
   output psr_pkt_type bcast,
   output logic arb_req,
   output psr_line_type tx_line,
   output logic short_reset_others,
   output logic notify_others,
   output logic resume_event,
   output logic long_reset,
   output logic reset_taken,
   output logic status_pkt,
   output logic cable_bias_output,
   output logic cable_bias_oe_b,
   output logic [7:0] control
);

   typedef struct packed {
      psr_state_type state;
      logic [TIMER_W-1:0] timer;
      logic [7:0] ctl;
      logic con;
      logic bias;
      logic node_rd_pend;
      psr_pkt_type rsp;
      psr_pkt_type bcast;
      logic arb_req;
      psr_line_type tx_line;
      logic short_reset_others;
      logic notify_others;
      logic resume_event;
      logic long_reset;
      logic reset_taken;
      logic status_pkt;
      logic bias_out;
      logic bias_oe_b;
   } psr_core_type;

   // Notify timer starts in the data-end cycle
   localparam logic [TIMER_W-1:0] NOTIFY_LOAD = TIMER_W'(NOTIFY_CYC);
   localparam logic [TIMER_W-1:0] BIAS_LOAD = TIMER_W'(BIAS_CYC - 1);
   localparam logic [TIMER_W-1:0] RESUME_LOAD = TIMER_W'(RESUME_DEBOUNCES * DEBOUNCE_CYCLES - 1);

   logic rst_meta_b;
   logic rst_sync_b;
   logic [7:0] node_rdata;
   psr_core_type s;
   psr_core_type next_s;

   function automatic logic [7:0] status_word(input psr_core_type c);
      logic [7:0] w;
      w = '0;
      w[ST_CON] = c.con;
      w[ST_BIAS] = c.bias;
      w[ST_SUSPEND] = c.ctl[CTL_SUSPEND];
      w[ST_DISABLE] = c.ctl[CTL_DISABLE];
      w[ST_FAULT] = c.ctl[CTL_FAULT];
      return w;
   endfunction : status_word

   function automatic logic [7:0] port_read(input psr_core_type c, input logic [2:0] sel);
      logic [7:0] w;
      w = '0;
      case (sel)
         REG_STATUS_FIRST: w = status_word(c);
         REG_STATUS_SECOND: begin
            w[ST2_INITIATOR] = (c.state == ST_INIT_NOTIFY);
            w[ST2_TARGET] = (c.state == ST_TGT_HOLD);
            w[ST2_RESUMING] = (c.state == ST_RESUME_WAIT);
         end
         REG_CONTROL_SET, REG_CONTROL_CLEAR: w = c.ctl;
         default: w = '0;
      endcase
      return w;
   endfunction : port_read

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   psr_node_regs #(
      .DEPTH(NODE_REGS),
      .AW(NODE_AW),
      .W(8)
   ) u_node_regs (
      .core_clk(core_clk),
      .rst_sync_b(rst_sync_b),
      .wr_en(node_wr_en),
      .wr_addr(node_wr_addr),
      .wr_data(node_wr_data),
      .rd_addr(req.sel),
      .rd_data(node_rdata)
   );

   always_comb begin
      logic do_resume;
      logic sel_init;
      logic live;
      do_resume = 1'b0;
      sel_init = 1'b0;
      next_s = s;
      next_s.rsp.valid = 1'b0;
      next_s.bcast.valid = 1'b0;
      next_s.short_reset_others = 1'b0;
      next_s.notify_others = 1'b0;
      next_s.resume_event = 1'b0;
      next_s.long_reset = 1'b0;
      next_s.reset_taken = 1'b0;
      next_s.status_pkt = 1'b0;
      next_s.node_rd_pend = 1'b0;
      next_s.con = conn_sense;
      next_s.bias = !bias_in_low;
      live = (s.state == ST_ACTIVE) && !s.ctl[CTL_DISABLE];
      if (s.timer != '0) begin
         next_s.timer = s.timer - 1'b1;
      end

      // node registers answer a cycle later
      if (s.node_rd_pend) begin
         next_s.rsp.valid = 1'b1;
         next_s.rsp.value = node_rdata;
      end

      if (req.valid && req.kind == TYPE_RESUME) begin
         if (req.port == RESUME_PORT && req.sel == REG_CONTROL_CLEAR && req.value == RESUME_VALUE) begin
            do_resume = 1'b1;
         end
      end else if (req.valid && req.port == PORT_SEL_NODE) begin
         next_s.node_rd_pend = 1'b1;
         next_s.rsp = '{valid: 1'b0, from_link: req.from_link, kind: TYPE_RESPONSE,
                        phy_id: node_id, port: req.port, sel: req.sel, value: 8'h00};
      end else if (req.valid && req.port == PORT_NUM && PORT_NUM <= PORT_SEL_MAX) begin
         next_s.rsp = '{valid: 1'b1, from_link: req.from_link, kind: TYPE_RESPONSE,
                        phy_id: node_id, port: req.port, sel: req.sel, value: port_read(s, req.sel)};
         if (req.kind == TYPE_WRITE) begin
            case (req.sel)
               REG_CONTROL_SET: begin
                  next_s.ctl = s.ctl | (req.value & CTL_WRITABLE);
                  sel_init = req.value[CTL_SUSPEND] && live;
               end
               REG_CONTROL_CLEAR: begin
                  next_s.ctl = s.ctl & ~(req.value & CTL_WRITABLE);
                  do_resume = req.value[CTL_SUSPEND];
               end
               default: next_s.ctl = s.ctl;
            endcase
         end
      end

      case (s.state)
         ST_ACTIVE: begin
            next_s.tx_line = LINE_IDLE;
            if (sel_init) begin
               next_s.state = req.from_link ? ST_INIT_ARB : ST_INIT_END;
               next_s.arb_req = req.from_link;
            end else if (live && bias_in_low) begin
               next_s.ctl[CTL_SUSPEND] = 1'b1;
               next_s.state = ST_BIAS_HOLD;
               next_s.timer = BIAS_LOAD;
               next_s.short_reset_others = 1'b1;
            end else if (live && rx_ident_done && !self_id_expected) begin
               next_s.notify_others = 1'b1;
               next_s.state = ST_TGT_HOLD;
               next_s.timer = BIAS_LOAD;
            end else if (live && bus_reset_in) begin
               next_s.reset_taken = 1'b1;
            end
         end
         ST_INIT_ARB: begin
            if (arb_grant) begin
               next_s.arb_req = 1'b0;
               next_s.bcast = '{valid: 1'b1, from_link: 1'b1, kind: TYPE_WRITE, phy_id: node_id,
                                port: PORT_NUM, sel: REG_CONTROL_SET, value: RESUME_VALUE};
               next_s.state = ST_INIT_END;
            end
         end
         ST_INIT_END: begin
            // data end, then reset and notify
            next_s.tx_line = LINE_DATA_END;
            next_s.state = ST_INIT_NOTIFY;
            next_s.timer = NOTIFY_LOAD;
         end
         ST_INIT_NOTIFY: begin
            if (s.tx_line == LINE_DATA_END) begin
               next_s.short_reset_others = 1'b1;
            end
            next_s.tx_line = LINE_SUSPEND_NOTIFY;
            if (bias_in_low) begin
               next_s.tx_line = LINE_IDLE;
               next_s.ctl[CTL_SUSPEND] = 1'b1;
               next_s.state = ST_BIAS_HOLD;
               next_s.timer = BIAS_LOAD;
            end else if (s.timer == '0) begin
               next_s.tx_line = LINE_IDLE;
               next_s.state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            next_s.ctl[CTL_SUSPEND] = 1'b1;
            if (conn_sense) begin
               next_s.ctl[CTL_FAULT] = 1'b1;
            end else begin
               next_s.ctl[CTL_FAULT] = 1'b0;
               next_s.ctl[CTL_DISABLE] = 1'b0;
               next_s.con = 1'b0;
               next_s.bias = 1'b0;
            end
            next_s.state = ST_SUSPENDED;
         end
         ST_BIAS_HOLD: begin
            if (s.timer == '0) begin
               next_s.state = ST_SUSPENDED;
            end
         end
         ST_TGT_HOLD: begin
            if (bias_in_low) begin
               next_s.ctl[CTL_SUSPEND] = 1'b1;
            end
            if (s.timer == '0) begin
               next_s.state = (s.ctl[CTL_SUSPEND] || bias_in_low) ? ST_SUSPENDED : ST_SAMPLE;
            end
         end
         ST_SUSPENDED: begin
            next_s.tx_line = LINE_IDLE;
            if (s.ctl[CTL_FAULT] && !conn_sense) begin
               next_s.ctl[CTL_FAULT] = 1'b0;
            end else if (s.ctl[CTL_FAULT] && s.bias && bias_in_low) begin
               next_s.ctl[CTL_FAULT] = 1'b0;
            end else if (!s.con && conn_sense && !s.ctl[CTL_FAULT]) begin
               do_resume = 1'b1;
            end
         end
         ST_RESUME_WAIT: begin
            if (bus_reset_in) begin
               next_s.reset_taken = 1'b1;
               next_s.state = ST_ACTIVE;
            end else if (s.timer == '0) begin
               next_s.long_reset = 1'b1;
               next_s.state = ST_ACTIVE;
            end
         end
         default: begin
            next_s.state = ST_ACTIVE;
         end
      endcase

      if (do_resume && s.state == ST_SUSPENDED && s.ctl[CTL_SUSPEND] && !next_s.ctl[CTL_DISABLE]
          && (conn_sense || s.con)) begin
         next_s.ctl[CTL_SUSPEND] = 1'b0;
         next_s.ctl[CTL_FAULT] = 1'b0;
         next_s.resume_event = 1'b1;
         next_s.state = ST_RESUME_WAIT;
         next_s.timer = RESUME_LOAD;
      end

      // no bias while suspended or disabled
      case (next_s.state)
         ST_BIAS_HOLD, ST_TGT_HOLD: begin
            next_s.bias_out = 1'b0;
            next_s.bias_oe_b = next_s.ctl[CTL_DISABLE];
         end
         ST_SAMPLE, ST_SUSPENDED: begin
            next_s.bias_out = 1'b0;
            next_s.bias_oe_b = 1'b1;
         end
         default: begin
            next_s.bias_out = 1'b1;
            next_s.bias_oe_b = next_s.ctl[CTL_DISABLE];
         end
      endcase

      if (s.ctl[CTL_CHG_INT_EN] && status_word(next_s) != status_word(s)) begin
         next_s.status_pkt = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         // Con starts high: no false reconnect at power-up
         s <= '{state: ST_SUSPENDED, timer: '0, ctl: CTL_RESET, con: 1'b1, bias: 1'b0,
                node_rd_pend: 1'b0, rsp: '0, bcast: '0, arb_req: 1'b0, tx_line: LINE_IDLE,
                short_reset_others: 1'b0, notify_others: 1'b0, resume_event: 1'b0,
                long_reset: 1'b0, reset_taken: 1'b0, status_pkt: 1'b0, bias_out: 1'b0,
                bias_oe_b: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign rsp = s.rsp;
   assign bcast = s.bcast;
   assign arb_req = s.arb_req;
   assign tx_line = s.tx_line;
   assign short_reset_others = s.short_reset_others;
   assign notify_others = s.notify_others;
   assign resume_event = s.resume_event;
   assign long_reset = s.long_reset;
   assign reset_taken = s.reset_taken;
   assign status_pkt = s.status_pkt;
   assign cable_bias_output = s.bias_out;
   assign cable_bias_oe_b = s.bias_oe_b;
   assign control = s.ctl;

endmodule : psr_port_suspend
